// ---- design/ctm_map.vh ----
// register map, field positions and constants of the cascaded 32-bit gated timer
// How it works
// - gated mode counts cycle ticks while gate high
// - 32-bit mode uses lower control, ignores upper gate
// - gate fall stops counting, count kept intact
// - gate falling edge sets period match flag
// - count equal period sets match flag bit 7
// - interrupt raised only when bit 7 enabled
// - period match emits one-shot adc trigger
// - prescale divides by 1, 8, 64, 256
// - input clock is cycle clock or external
// - only lower prescaler used in 32-bit mode
// - prescaler clears on count write, timer off, reset
// - disabled timer leaves lower prescaler untouched
// - control writes do not clear the count
// - no counting while cpu sleeps
`ifndef CTM_MAP_VH
`define CTM_MAP_VH

// register offsets
`define CTM_A_CTRL_LOW    4'h0
`define CTM_A_CTRL_HIGH   4'h1
`define CTM_A_COUNT_LOW   4'h2
`define CTM_A_COUNT_HIGH  4'h3
`define CTM_A_PERIOD_LOW  4'h4
`define CTM_A_PERIOD_HIGH 4'h5
`define CTM_A_IRQ_FLAG    4'h6
`define CTM_A_IRQ_EN      4'h7

// control and interrupt field positions
`define CTM_B_TIMER_ON    15
`define CTM_B_GATE_EN     6
`define CTM_B_PS_HI       5
`define CTM_B_PS_LO       4
`define CTM_B_CLK_SEL     1
`define CTM_B_MATCH       7

// reset values
`define CTM_RST_CTRL      16'h0000
`define CTM_RST_COUNT     16'h0000
`define CTM_RST_PERIOD    16'hffff
`define CTM_RST_PS        8'h00

// prescale terminal counts (divide minus one)
`define CTM_PS_DIV1       8'h00
`define CTM_PS_DIV8       8'h07
`define CTM_PS_DIV64      8'h3f
`define CTM_PS_DIV256     8'hff

// oscillator clock divided by this plus one gives the cycle clock
`define CTM_OSC_DIV_M1    2'h3

`endif

// ---- design/ctm_timer.v ----
// cascaded 32-bit gated timer with register port and level interrupt
`timescale 1ns/1ps
`include "ctm_map.vh"

module ctm_timer
(
    input  wire        clk,
    input  wire        nrst,
    input  wire [3:0]  addr,
    input  wire [15:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [15:0] rdata,
    input  wire        gate_input_pin,
    input  wire        ext_clk_tick,
    input  wire        cpu_sleep,
    output wire        irq,
    output reg         adc_trigger
);

    reg  [15:0] ctrl_low_q;
    reg  [15:0] ctrl_high_q;
    reg  [15:0] count_low_q;
    reg  [15:0] count_high_q;
    reg  [15:0] period_low_q;
    reg  [15:0] period_high_q;
    reg         flag_q;
    reg         irq_en_q;
    reg  [7:0]  ps_q;
    reg  [1:0]  osc_div_q;
    reg         gate_q;
    reg         wrap_q;

    wire        timer_on  = ctrl_low_q[`CTM_B_TIMER_ON];
    wire        gate_en   = ctrl_low_q[`CTM_B_GATE_EN];
    wire        clk_sel   = ctrl_low_q[`CTM_B_CLK_SEL];
    wire [1:0]  ps_sel    = ctrl_low_q[`CTM_B_PS_HI:`CTM_B_PS_LO];
    wire [31:0] count     = {count_high_q, count_low_q};
    wire [31:0] period    = {period_high_q, period_low_q};
    wire        cyc_tick  = (osc_div_q == `CTM_OSC_DIV_M1) && !cpu_sleep;
    // gated mode always runs on the cycle clock; clock select is ignored while gate enable is set
    wire        src_tick  = (clk_sel && !gate_en) ? (ext_clk_tick && !cpu_sleep)
                                                  : cyc_tick;
    wire        gate_fall = gate_en && gate_q && !gate_input_pin;
    wire        wr_cnt    = wr && (addr == `CTM_A_COUNT_LOW || addr == `CTM_A_COUNT_HIGH);
    // only a one-to-zero change of a run bit counts as switching the timer off
    wire        off_wr    = wr && timer_on && !wdata[`CTM_B_TIMER_ON] &&
                            (addr == `CTM_A_CTRL_LOW ||
                             (addr == `CTM_A_CTRL_HIGH && ctrl_high_q[`CTM_B_TIMER_ON]));
    reg  [7:0]  ps_term;
    wire        ps_done   = (ps_q == ps_term);
    wire        run       = timer_on && (!gate_en || gate_input_pin);
    wire        cnt_tick  = run && src_tick && ps_done;
    wire        match     = (count == period);
    wire        match_hit = cnt_tick && match && !wrap_q;

    // prescale select decode
    always @*
    begin
        case (ps_sel)
            2'h0:    ps_term = `CTM_PS_DIV1;
            2'h1:    ps_term = `CTM_PS_DIV8;
            2'h2:    ps_term = `CTM_PS_DIV64;
            default: ps_term = `CTM_PS_DIV256;
        endcase
    end

    // free-running divide by four of the oscillator clock, stopped in sleep
    always @(posedge clk)
    begin
        if (!nrst)
            osc_div_q <= 2'h0;
        else if (!cpu_sleep)
            osc_div_q <= osc_div_q + 2'h1;
    end

    // prescaler: only advances while running, so a timer halted by its gate keeps its phase
    always @(posedge clk)
    begin
        if (!nrst)
            ps_q <= `CTM_RST_PS;
        else if (timer_on && (wr_cnt || off_wr))
            ps_q <= `CTM_RST_PS;
        else if (run && src_tick)
            ps_q <= ps_done ? `CTM_RST_PS : ps_q + 8'h01;
    end

    // gate sampler for edge detection; the pin is already synchronous
    always @(posedge clk)
    begin
        if (!nrst)
            gate_q <= 1'b0;
        else
            gate_q <= gate_input_pin;
    end

    // 32-bit count with carry; software writes win over counting
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            count_low_q  <= `CTM_RST_COUNT;
            count_high_q <= `CTM_RST_COUNT;
            wrap_q       <= 1'b0;
        end
        else if (wr_cnt)
        begin
            if (addr == `CTM_A_COUNT_LOW)
                count_low_q <= wdata;
            else
                count_high_q <= wdata;
            wrap_q <= 1'b0;
        end
        else if (cnt_tick)
        begin
            // a match in gated mode keeps accumulating; otherwise wrap on next tick
            if (wrap_q)
            begin
                count_low_q  <= `CTM_RST_COUNT;
                count_high_q <= `CTM_RST_COUNT;
                wrap_q       <= 1'b0;
            end
            else
            begin
                {count_high_q, count_low_q} <= count + 32'h0000_0001;
                wrap_q <= match && !gate_en;
            end
        end
    end

    // control, period and interrupt registers; control writes leave the count alone
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            ctrl_low_q    <= `CTM_RST_CTRL;
            ctrl_high_q   <= `CTM_RST_CTRL;
            period_low_q  <= `CTM_RST_PERIOD;
            period_high_q <= `CTM_RST_PERIOD;
            irq_en_q      <= 1'b0;
        end
        else if (wr)
        begin
            case (addr)
                `CTM_A_CTRL_LOW:    ctrl_low_q    <= wdata;
                `CTM_A_CTRL_HIGH:   ctrl_high_q   <= wdata;
                `CTM_A_PERIOD_LOW:  period_low_q  <= wdata;
                `CTM_A_PERIOD_HIGH: period_high_q <= wdata;
                `CTM_A_IRQ_EN:      irq_en_q      <= wdata[`CTM_B_MATCH];
                default:            irq_en_q      <= irq_en_q;
            endcase
        end
    end

    // sticky match flag, cleared by writing one; a new event beats the clear
    always @(posedge clk)
    begin
        if (!nrst)
            flag_q <= 1'b0;
        else if (match_hit || gate_fall)
            flag_q <= 1'b1;
        else if (wr && addr == `CTM_A_IRQ_FLAG && wdata[`CTM_B_MATCH])
            flag_q <= 1'b0;
    end

    assign irq = flag_q && irq_en_q;

    // one-cycle trigger toward the converter
    always @(posedge clk)
    begin
        if (!nrst)
            adc_trigger <= 1'b0;
        else
            adc_trigger <= match_hit;
    end

    // read data one cycle after the strobe, zero otherwise
    always @(posedge clk)
    begin
        if (!nrst)
            rdata <= 16'h0000;
        else if (rd)
        begin
            case (addr)
                `CTM_A_CTRL_LOW:    rdata <= ctrl_low_q;
                `CTM_A_CTRL_HIGH:   rdata <= ctrl_high_q;
                `CTM_A_COUNT_LOW:   rdata <= count_low_q;
                `CTM_A_COUNT_HIGH:  rdata <= count_high_q;
                `CTM_A_PERIOD_LOW:  rdata <= period_low_q;
                `CTM_A_PERIOD_HIGH: rdata <= period_high_q;
                `CTM_A_IRQ_FLAG:    rdata <= {8'h00, flag_q, 7'h00};
                `CTM_A_IRQ_EN:      rdata <= {8'h00, irq_en_q, 7'h00};
                default:            rdata <= 16'h0000;
            endcase
        end
        else
            rdata <= 16'h0000;
    end

endmodule // ctm_timer

// ---- test/ctm_pin_model.sv ----
// pin-side model: gate level and external clock ticks
`timescale 1ns/1ps
module ctm_pin_model
(
    input  wire logic clk,
    input  wire logic gate_cmd,
    input  wire logic ext_run,
    output logic      gate_input_pin = 1'b0,
    output logic      ext_clk_tick = 1'b0
);
    // gate lags the command a cycle; ext ticks every other cycle, idle low
    always @(posedge clk)
    begin
        gate_input_pin <= gate_cmd;
        ext_clk_tick   <= ext_run & ~ext_clk_tick;
    end
endmodule // ctm_pin_model

// ---- test/ctm_timer_asserts.sv ----
// port-level assertions for the cascaded timer
`timescale 1ns/1ps
module ctm_timer_asserts
(
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [3:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata,
    input wire logic        gate_input_pin,
    input wire logic        cpu_sleep,
    input wire logic        irq,
    input wire logic        adc_trigger
);
    logic on_q, gate_q, en_q;
    // shadow bits, loaded on the same edge as the design's own
    always @(posedge clk)
        if (!nrst) {on_q, gate_q, en_q} <= 3'h0;
        else if (wr && addr == 4'h0) {on_q, gate_q} <= {wdata[15], wdata[6]};
        else if (wr && addr == 4'h7) en_q <= wdata[7];
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence fall_s; gate_q && on_q && en_q && $fell(gate_input_pin); endsequence
    sequence shut_s; (gate_q && !gate_input_pin)[*2]; endsequence
    irq_mask_a: assert property (irq |-> en_q) else $error("irq masked");
    flag_hold_a: assert property (irq && !wr |=> irq) else $error("flag lost");
    gate_fall_a: assert property (fall_s |-> ##[1:2] irq) else $error("no fall");
    gate_shut_a: assert property (shut_s |=> !adc_trigger) else $error("gated");
    adc_pulse_a: assert property (adc_trigger |=> !adc_trigger[*3]) else $error("adc");
    adc_flag_a: assert property (adc_trigger && en_q |-> irq) else $error("no flag");
    sleep_stop_a: assert property (cpu_sleep |=> !adc_trigger) else $error("sleep");
    rd_idle_a: assert property (!$past(rd) |-> rdata == 16'h0000) else $error("rdata");
endmodule // ctm_timer_asserts
bind ctm_timer ctm_timer_asserts ctm_timer_asserts_inst (.clk(clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .gate_input_pin(gate_input_pin),
    .cpu_sleep(cpu_sleep), .irq(irq), .adc_trigger(adc_trigger));

// ---- test/tb_ctm_timer.sv ----
// self-checking bench for the cascaded timer
`timescale 1ns/1ps
module tb_ctm_timer;
    logic        clk, nrst, wr, rd, gate_cmd, ext_run, cpu_sleep;
    logic [3:0]  addr;
    logic [15:0] wdata;
    wire  [15:0] rdata;
    wire         gate_input_pin, ext_clk_tick, irq, adc_trigger;
    int          n_mismatch, n_tests, i, n;
    int          div [4] = '{1, 8, 64, 256};
    ctm_timer ctm_timer_inst (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .gate_input_pin(gate_input_pin), .ext_clk_tick(ext_clk_tick),
        .cpu_sleep(cpu_sleep), .irq(irq), .adc_trigger(adc_trigger));
    ctm_pin_model ctm_pin_model_inst (.clk(clk), .gate_cmd(gate_cmd), .ext_run(ext_run),
        .gate_input_pin(gate_input_pin), .ext_clk_tick(ext_clk_tick));
    task automatic test_done();
        if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) $display("MISMATCH %0t got %h want %h", $time, got, exp);
        if (got !== exp) n_mismatch++;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        {rd, addr} <= {1'b1, a};
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(rdata, exp);
    endtask
    // bounded wait for a trigger pulse; n ends one short of the gap
    task automatic wait_adc();
        n = 0;
        @(negedge clk);
        while (adc_trigger !== 1'b1 && n < 6000)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 6000) n_mismatch++;
        if (n >= 6000) test_done();
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        {nrst, wr, rd, gate_cmd, ext_run, cpu_sleep, addr, wdata} = 26'h0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        rd_chk(4'h5, 16'hffff);
        rd_chk(4'hf, 16'h0000);
        wr_reg(4'h4, 16'h0003);
        wr_reg(4'h5, 16'h0000);
        wr_reg(4'h7, 16'h0080);
        wr_reg(4'h1, 16'h8070);
        // match gap is period+2 ticks of four clocks times the divide
        for (i = 0; i < 4; i++)
        begin
            wr_reg(4'h0, {8'h80, 2'h0, i[1:0], 4'h0});
            wr_reg(4'h2, 16'h0000);
            wait_adc();
            wait_adc();
            check(n + 1, 20 * div[i]);
        end
        check(irq, 1'b1);
        wr_reg(4'h6, 16'h0080);
        wr_reg(4'h7, 16'h0000);
        wait_adc();
        check(irq, 1'b0);
        wr_reg(4'h7, 16'h0080);
        @(negedge clk);
        check(irq, 1'b1);
        ext_run <= 1'b1;
        wr_reg(4'h0, 16'h8002);
        wait_adc();
        wait_adc();
        check(n + 1, 10);
        cpu_sleep <= 1'b1;
        wr_reg(4'h2, 16'h0000);
        repeat (100) @(posedge clk);
        rd_chk(4'h2, 16'h0000);
        {cpu_sleep, ext_run} <= 2'h0;
        // gated: 40 clocks of gate high hold exactly ten cycle ticks
        wr_reg(4'h4, 16'hffff);
        wr_reg(4'h5, 16'hffff);
        wr_reg(4'h0, 16'h8040);
        wr_reg(4'h2, 16'h0000);
        wr_reg(4'h6, 16'h0080);
        gate_cmd <= 1'b1;
        repeat (40) @(posedge clk);
        gate_cmd <= 1'b0;
        repeat (4) @(negedge clk);
        check(irq, 1'b1);
        rd_chk(4'h2, 16'h000a);
        wr_reg(4'h0, 16'h8040);
        rd_chk(4'h2, 16'h000a);
        rd_chk(4'h3, 16'h0000);
        test_done();
    end
endmodule // tb_ctm_timer
